/* File: fdr_flow_host.sv */
// Host end: link master that reads, checks and scales one flow frame.
`timescale 1ns/1ps
`default_nettype none
module fdr_flow_host #(
  parameter int QTR_CYCLES = fdr_pkg::FDR_QTR_CYC_STD
) (
  fdr_i2c_if.master          bus,
  input  wire logic          clk_sys_in,
  input  wire logic          rst_in,
  input  wire logic          read_req_in,
  output logic               busy_out,
  output logic               done_out,
  output logic               addr_nack_out,
  output logic               frame_ok_out,
  output logic [11:0]        flow_count_out,
  output logic [15:0]        tail_out,
  output logic [10:0]        flow_dlpm_out
);
  import fdr_pkg::*;

  fdr_host_state_t state_reg;
  logic [15:0]     q_cnt_reg;
  logic [1:0]      phase_reg;
  logic [3:0]      bit_cnt_reg;
  logic [2:0]      byte_cnt_reg;
  logic [7:0]      rx_shift_reg;
  logic [7:0]      rx_mem_reg [FDR_FRAME_BYTES];
  logic            nack_reg;
  logic            scl_oe_reg;
  logic            sda_oe_reg;
  logic            sda_s1_reg;
  logic            sda_s2_reg;
  logic            tick;
  logic            drive_low;
  logic            finish;
  logic [11:0]     counts;
  logic [22:0]     scaled;

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_oe = sda_oe_reg;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end
    else
    begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      q_cnt_reg <= 16'h0000;
    else if (state_reg == MS_IDLE || tick)
      q_cnt_reg <= 16'h0000;
    else
      q_cnt_reg <= q_cnt_reg + 16'h0001;
  end

  assign tick   = (state_reg != MS_IDLE) && (q_cnt_reg == 16'(QTR_CYCLES - 1));
  assign finish = tick && (state_reg == MS_STOP) && (phase_reg == 2'h3);

  always_comb
  begin
    if (bit_cnt_reg != FDR_ACK_BIT)
      drive_low = (byte_cnt_reg == FDR_IDX_CKS) && !FDR_ADDR_RD[3'h7 - bit_cnt_reg[2:0]];
    else
      drive_low = (byte_cnt_reg != FDR_IDX_CKS) && (byte_cnt_reg != FDR_IDX_END);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg    <= MS_IDLE;
      phase_reg    <= 2'h0;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 3'h0;
      rx_shift_reg <= FDR_BYTE_RST;
      nack_reg     <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      for (int i = 0; i < FDR_FRAME_BYTES; i++)
        rx_mem_reg[i] <= FDR_BYTE_RST;
    end
    else if (state_reg == MS_IDLE)
    begin
      phase_reg <= 2'h0;
      if (read_req_in)
      begin
        state_reg <= MS_START;
        nack_reg  <= 1'b0;
      end
    end
    else if (tick)
    begin
      phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        MS_START:
        begin
          if (phase_reg == 2'h1)
            sda_oe_reg <= 1'b1;
          if (phase_reg == 2'h3)
          begin
            scl_oe_reg   <= 1'b1;
            state_reg    <= MS_BIT;
            bit_cnt_reg  <= 4'h0;
            byte_cnt_reg <= 3'h0;
          end
        end
        MS_BIT:
        begin
          case (phase_reg)
            2'h0: sda_oe_reg <= drive_low;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2:
            begin
              if (bit_cnt_reg != FDR_ACK_BIT)
                rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
              else if (byte_cnt_reg == FDR_IDX_CKS && sda_s2_reg != FDR_ACK)
                nack_reg <= 1'b1;
            end
            default:
            begin
              scl_oe_reg <= 1'b1;
              if (bit_cnt_reg == FDR_ACK_BIT)
              begin
                bit_cnt_reg <= 4'h0;
                if (byte_cnt_reg != FDR_IDX_CKS)
                  rx_mem_reg[byte_cnt_reg - 3'h1] <= rx_shift_reg;
                if (nack_reg || byte_cnt_reg == FDR_IDX_END)
                  state_reg <= MS_STOP;
                else
                  byte_cnt_reg <= byte_cnt_reg + 3'h1;
              end
              else
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          endcase
        end
        MS_STOP:
        begin
          case (phase_reg)
            2'h0:    sda_oe_reg <= 1'b1;
            2'h1:    scl_oe_reg <= 1'b0;
            2'h2:    sda_oe_reg <= 1'b0;
            default: state_reg  <= MS_IDLE;
          endcase
        end
        default:
          state_reg <= MS_IDLE;
      endcase
    end
  end

  assign counts = (rx_mem_reg[1][3:0] > FDR_FLOW_OFFSET[11:8] ||
                   (rx_mem_reg[1][3:0] == FDR_FLOW_OFFSET[11:8] &&
                    rx_mem_reg[2] >= FDR_FLOW_OFFSET[7:0])) ?
                  {rx_mem_reg[1][3:0], rx_mem_reg[2]} - FDR_FLOW_OFFSET : 12'h000;
  assign scaled = ({11'h000, counts} * FDR_FLOW_FULL * FDR_FLOW_DECI) / FDR_FLOW_SPAN;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      addr_nack_out  <= 1'b0;
      frame_ok_out   <= 1'b0;
      flow_count_out <= FDR_FLOW_RST;
      tail_out       <= 16'h0000;
      flow_dlpm_out  <= 11'h000;
    end
    else
    begin
      busy_out <= (state_reg != MS_IDLE || read_req_in) && !finish;
      done_out <= finish;
      if (finish)
      begin
        addr_nack_out  <= nack_reg;
        frame_ok_out   <= !nack_reg && ((rx_mem_reg[0] + fdr_sum4(rx_mem_reg[1],
                          rx_mem_reg[2], rx_mem_reg[3], rx_mem_reg[4])) == 8'h00);
        flow_count_out <= {rx_mem_reg[1][3:0], rx_mem_reg[2]};
        tail_out       <= {rx_mem_reg[3], rx_mem_reg[4]};
        flow_dlpm_out  <= scaled[10:0];
      end
    end
  end

endmodule : fdr_flow_host
`default_nettype wire

/* File: fdr_i2c_if.sv */
// Two-wire open-drain link joining the host end and the sensor end.
`timescale 1ns/1ps
`default_nettype none
interface fdr_i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: a line is low while any enabled driver drives low.
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input  scl,
    input  sda
  );

  modport slave (
    output s_sda_o,
    output s_sda_oe,
    input  scl,
    input  sda
  );
endinterface : fdr_i2c_if
`default_nettype wire

/* File: fdr_link_monitor.sv */
// Protocol checker watching the two-wire link between host and sensor.
`timescale 1ns/1ps
`default_nettype none
module fdr_link_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import fdr_pkg::*;
  logic       scl_q;
  logic       sda_q;
  logic       in_xfer;
  logic       acked;
  logic [5:0] bit_cnt;
  logic [3:0] slot;
  logic [7:0] addr_sh;
  wire logic  rise  = scl && !scl_q;
  wire logic  start = scl && scl_q && sda_q && !sda;
  wire logic  stop  = scl && scl_q && !sda_q && sda;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      in_xfer <= 1'b0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
        in_xfer <= 1'b1;
      else if (stop)
        in_xfer <= 1'b0;
    end
  end

  // Counts bit slots from the last start so each check knows its place in the frame.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bit_cnt <= 6'h00;
      slot    <= 4'h0;
      addr_sh <= 8'h00;
      acked   <= 1'b0;
    end
    else if (start)
    begin
      bit_cnt <= 6'h00;
      slot    <= 4'h0;
      acked   <= 1'b0;
    end
    else if (rise)
    begin
      bit_cnt <= bit_cnt + 6'h01;
      slot    <= (slot == 4'h8) ? 4'h0 : slot + 4'h1;
      if (bit_cnt < 6'h08)
        addr_sh <= {addr_sh[6:0], sda};
      if (bit_cnt == 6'h08)
        acked <= !sda;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_addr_ack:
    assert property (rise && bit_cnt == 6'h08 && addr_sh == FDR_ADDR_RD |-> !sda && s_sda_oe)
    else $error("read address was not acknowledged");
  a_resp_free:
    assert property (rise && slot == 4'h8 && bit_cnt > 6'h08 |-> !s_sda_oe)
    else $error("sensor drove a host response slot");
  a_hold_high:
    assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("sensor changed data while clock high");
  a_quiet_idle:
    assert property (!in_xfer |-> !s_sda_oe)
    else $error("sensor drove data outside a transfer");
  // The clock rise that sets up a STOP is counted too, so a clean end sits in slot one.
  a_whole_bytes:
    assert property (stop |-> slot == 4'h1 && bit_cnt >= 6'h0a)
    else $error("stop inside a nine bit unit");
  a_frame_five:
    assert property (stop && acked |-> bit_cnt == 6'h37)
    else $error("frame length not five bytes");
  a_last_nack:
    assert property (rise && acked && bit_cnt == 6'h35 |-> sda)
    else $error("last byte was acknowledged");
  a_data_ack:
    assert property (rise && acked && slot == 4'h8 && bit_cnt > 6'h08 && bit_cnt < 6'h35 |-> !sda)
    else $error("host failed to acknowledge a byte");
  a_high_nibble:
    assert property (rise && acked && bit_cnt >= 6'h12 && bit_cnt <= 6'h15 |-> !sda)
    else $error("upper nibble of flow high byte not zero");
endmodule : fdr_link_monitor
`default_nettype wire

/* File: fdr_pkg.sv */
// Shared constants, types and frame helpers for the flow data readout link.
package fdr_pkg;

  // Bus address and direction of the only command the sensor answers.
  localparam logic [6:0]  FDR_ADDR        = 7'h50;
  localparam logic        FDR_DIR_READ    = 1'b1;
  localparam logic [7:0]  FDR_ADDR_RD     = {FDR_ADDR, FDR_DIR_READ};
  localparam logic        FDR_ACK         = 1'b0;

  // Frame layout: checksum, flow high, flow low, two trailing bytes.
  localparam int          FDR_FRAME_BYTES = 5;
  localparam logic [2:0]  FDR_IDX_CKS     = 3'h0;
  localparam logic [2:0]  FDR_IDX_HI      = 3'h1;
  localparam logic [2:0]  FDR_IDX_LO      = 3'h2;
  localparam logic [2:0]  FDR_IDX_HI2     = 3'h3;
  localparam logic [2:0]  FDR_IDX_LO2     = 3'h4;
  localparam logic [2:0]  FDR_IDX_END     = 3'h5;
  localparam logic [7:0]  FDR_IDLE_BYTE   = 8'hff;
  localparam logic [3:0]  FDR_ACK_BIT     = 4'h8;
  localparam logic [2:0]  FDR_LAST_BIT    = 3'h7;

  // Reset values.
  localparam logic [11:0] FDR_FLOW_RST    = 12'h000;
  localparam logic [7:0]  FDR_BYTE_RST    = 8'h00;

  // Link timing: each bit is four quarter periods, each QTR_CYCLES system clock cycles long.
  localparam int          FDR_SYS_CLK_HZ  = 100_000_000;
  localparam int          FDR_BUS_HZ_STD  = 100_000;
  localparam int          FDR_BUS_HZ_FAST = 400_000;
  localparam int          FDR_QTR_CYC_STD  = FDR_SYS_CLK_HZ / (4 * FDR_BUS_HZ_STD);
  localparam int          FDR_QTR_CYC_FAST = FDR_SYS_CLK_HZ / (4 * FDR_BUS_HZ_FAST);

  // Count to flow conversion, result in tenths of a litre per minute.
  localparam logic [11:0] FDR_FLOW_OFFSET = 12'h199;
  localparam logic [22:0] FDR_FLOW_SPAN   = 23'h000ccd;
  localparam logic [22:0] FDR_FLOW_FULL   = 23'h0000c8;
  localparam logic [22:0] FDR_FLOW_DECI   = 23'h00000a;

  typedef enum logic [2:0] {
    DS_IDLE,
    DS_ADDR,
    DS_ADDR_ACK,
    DS_TX,
    DS_TX_ACK,
    DS_IGNORE
  } fdr_dev_state_t;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_START,
    MS_BIT,
    MS_STOP
  } fdr_host_state_t;

  function automatic logic [7:0] fdr_sum4(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c, input logic [7:0] d);
    fdr_sum4 = a + b + c + d;
  endfunction : fdr_sum4

  function automatic logic [7:0] fdr_frame_byte(input logic [2:0]  idx,
                                                input logic [11:0] flow,
                                                input logic        rep);
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] hi2;
    logic [7:0] lo2;
    hi  = {4'h0, flow[11:8]};
    lo  = flow[7:0];
    hi2 = rep ? hi : 8'h00;
    lo2 = rep ? lo : 8'h00;
    case (idx)
      FDR_IDX_CKS: fdr_frame_byte = 8'h00 - fdr_sum4(hi, lo, hi2, lo2);
      FDR_IDX_HI:  fdr_frame_byte = hi;
      FDR_IDX_LO:  fdr_frame_byte = lo;
      FDR_IDX_HI2: fdr_frame_byte = hi2;
      FDR_IDX_LO2: fdr_frame_byte = lo2;
      default:     fdr_frame_byte = FDR_IDLE_BYTE;
    endcase
  endfunction : fdr_frame_byte

endpackage : fdr_pkg

/* File: fdr_sensor_dev.sv */
// Sensor end: read-only flow data responder clocked by the link clock.
// Functional notes
// - Acknowledge only address 50 hex, ignore others.
// - Falling SDA while SCL high starts transfer.
// - Rising SDA while SCL high ends transfer.
// - Eight data bits then one response bit.
// - After acknowledge, master continues or stops.
// - Pull SDA low on ack, then release.
// - Master treats undriven response as not-acknowledge.
// - Sample on SCL rise, hold during high.
// - Always serve latest sample, no trigger; a sample arriving while an earlier one awaits a read can replace it during that read's address bits.
// - Every byte shifted most significant bit first.
// - Master sends start, address, read bit.
// - Send checksum first, then flow bytes.
// - Flow is 12 bits; high nibble zero.
// - Five byte frame, tail repeats or zero.
// - Checksum is negated modulo-256 data sum.
// - Master accepts frame when total sums zero.
// - Master scales counts to litres per minute.
// - Works at 100 kHz and 400 kHz.
`timescale 1ns/1ps
`default_nettype none
module fdr_sensor_dev (
  fdr_i2c_if.slave           bus,
  input  wire logic          clk_sys_in,
  input  wire logic          rst_in,
  input  wire logic [11:0]   flow_in,
  input  wire logic          flow_valid_in,
  input  wire logic          repeat_mode_in,
  output logic               frame_end_out,
  output logic               read_served_out
);
  import fdr_pkg::*;

  // System domain: latest measurement and its publication.
  logic [11:0]    latest_reg;
  logic           latest_rep_reg;
  logic           pending_reg;
  logic [12:0]    shadow_reg;
  logic           shadow_tgl_reg;
  logic           pub_ack_s1_reg;
  logic           pub_ack_s2_reg;
  logic           stop_s1_reg;
  logic           stop_s2_reg;
  logic           stop_s3_reg;
  logic           srv_s1_reg;
  logic           srv_s2_reg;
  logic           srv_s3_reg;

  // Link domain.
  fdr_dev_state_t state_reg;
  logic [6:0]     shift_reg;
  logic [2:0]     bit_cnt_reg;
  logic [2:0]     byte_idx_reg;
  logic           start_tgl_reg;
  logic           start_ack_reg;
  logic           stop_tgl_reg;
  logic           req_s1_reg;
  logic           req_s2_reg;
  logic           snap_ack_reg;
  logic [12:0]    snap_reg;
  logic           served_tgl_reg;
  logic           sda_oe_reg;
  logic           start_pend;
  logic [7:0]     cur_byte;

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe_reg;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      latest_reg     <= FDR_FLOW_RST;
      latest_rep_reg <= 1'b0;
    end
    else if (flow_valid_in)
    begin
      latest_reg     <= flow_in;
      latest_rep_reg <= repeat_mode_in;
    end
  end

  // A new sample arriving in the cycle of publication keeps the flag set.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pending_reg    <= 1'b0;
      shadow_reg     <= {1'b0, FDR_FLOW_RST};
      shadow_tgl_reg <= 1'b0;
    end
    else if (pending_reg && (shadow_tgl_reg == pub_ack_s2_reg))
    begin
      shadow_reg     <= {latest_rep_reg, latest_reg};
      shadow_tgl_reg <= ~shadow_tgl_reg;
      pending_reg    <= flow_valid_in;
    end
    else if (flow_valid_in)
    begin
      pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pub_ack_s1_reg <= 1'b0;
      pub_ack_s2_reg <= 1'b0;
      stop_s1_reg    <= 1'b0;
      stop_s2_reg    <= 1'b0;
      stop_s3_reg    <= 1'b0;
      srv_s1_reg     <= 1'b0;
      srv_s2_reg     <= 1'b0;
      srv_s3_reg     <= 1'b0;
    end
    else
    begin
      pub_ack_s1_reg <= snap_ack_reg;
      pub_ack_s2_reg <= pub_ack_s1_reg;
      stop_s1_reg    <= stop_tgl_reg;
      stop_s2_reg    <= stop_s1_reg;
      stop_s3_reg    <= stop_s2_reg;
      srv_s1_reg     <= served_tgl_reg;
      srv_s2_reg     <= srv_s1_reg;
      srv_s3_reg     <= srv_s2_reg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      frame_end_out   <= 1'b0;
      read_served_out <= 1'b0;
    end
    else
    begin
      frame_end_out   <= stop_s2_reg ^ stop_s3_reg;
      read_served_out <= srv_s2_reg ^ srv_s3_reg;
    end
  end

  // The link clock stands still between frames, so START and STOP are caught
  // on edges of the data line itself, with the clock level as qualifier.
  // start detect
  always_ff @(negedge bus.sda or posedge rst_in)
  begin
    if (rst_in)
      start_tgl_reg <= 1'b0;
    else if (bus.scl)
      start_tgl_reg <= ~start_tgl_reg;
  end

  always_ff @(posedge bus.sda or posedge rst_in)
  begin
    if (rst_in)
      stop_tgl_reg <= 1'b0;
    else if (bus.scl)
      stop_tgl_reg <= ~stop_tgl_reg;
  end

  // The start toggle settles a full high phase before the next clock edge.
  assign start_pend = start_tgl_reg ^ start_ack_reg;

  always_ff @(posedge bus.scl or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg     <= DS_IDLE;
      shift_reg     <= 7'h00;
      bit_cnt_reg   <= 3'h0;
      byte_idx_reg  <= FDR_IDX_CKS;
      start_ack_reg <= 1'b0;
    end
    else
    begin
      start_ack_reg <= start_tgl_reg;
      if (start_pend)
      begin
        state_reg   <= DS_ADDR;
        shift_reg   <= {6'h00, bus.sda};
        bit_cnt_reg <= 3'h1;
      end
      else
      begin
        case (state_reg)
          DS_ADDR:
          begin
            shift_reg   <= {shift_reg[5:0], bus.sda};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == FDR_LAST_BIT)
              state_reg <= (shift_reg == FDR_ADDR && bus.sda == FDR_DIR_READ) ?
                           DS_ADDR_ACK : DS_IGNORE;
          end
          DS_ADDR_ACK:
          begin
            state_reg    <= DS_TX;
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= FDR_IDX_CKS;
          end
          DS_TX:
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == FDR_LAST_BIT)
              state_reg <= DS_TX_ACK;
          end
          DS_TX_ACK:
          begin
            if (bus.sda == FDR_ACK)
            begin
              state_reg   <= DS_TX;
              bit_cnt_reg <= 3'h0;
              if (byte_idx_reg != FDR_IDX_END)
                byte_idx_reg <= byte_idx_reg + 3'h1;
            end
            else
              state_reg <= DS_IGNORE;
          end
          default:
            state_reg <= state_reg;
        endcase
      end
    end
  end

  always_ff @(posedge bus.scl or posedge rst_in)
  begin
    if (rst_in)
      served_tgl_reg <= 1'b0;
    else if (!start_pend && state_reg == DS_ADDR && bit_cnt_reg == FDR_LAST_BIT &&
             shift_reg == FDR_ADDR && bus.sda == FDR_DIR_READ)
      served_tgl_reg <= ~served_tgl_reg;
  end

  // The snapshot is frozen once data leaves, so one frame never mixes samples.
  // take published sample
  always_ff @(posedge bus.scl or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      snap_ack_reg <= 1'b0;
      snap_reg     <= {1'b0, FDR_FLOW_RST};
    end
    else
    begin
      req_s1_reg <= shadow_tgl_reg;
      req_s2_reg <= req_s1_reg;
      if ((req_s2_reg != snap_ack_reg) &&
          (state_reg == DS_IDLE || state_reg == DS_ADDR || state_reg == DS_IGNORE))
      begin
        snap_reg     <= shadow_reg;
        snap_ack_reg <= req_s2_reg;
      end
    end
  end

  assign cur_byte = fdr_frame_byte(byte_idx_reg, snap_reg[11:0], snap_reg[12]);

  // Drive changes only while the clock is low, keeping data stable when high.
  // ack then release
  always_ff @(negedge bus.scl or posedge rst_in)
  begin
    if (rst_in)
      sda_oe_reg <= 1'b0;
    else if (start_pend)
      sda_oe_reg <= 1'b0;
    else
    begin
      case (state_reg)
        DS_ADDR_ACK: sda_oe_reg <= 1'b1;
        DS_TX:       sda_oe_reg <= !cur_byte[FDR_LAST_BIT - bit_cnt_reg];
        default:     sda_oe_reg <= 1'b0;
      endcase
    end
  end

endmodule : fdr_sensor_dev
`default_nettype wire

/* File: tb_i2c_flow_data_readout.sv */
// Self-checking bench joining host and sensor ends over the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_flow_data_readout;
  import fdr_pkg::*;
  localparam int Q = 4;
  logic        clk_sys_in, rst_in, dev_rst, read_req_in, flow_valid_in, repeat_mode_in;
  logic [11:0] flow_in, flow_count_out;
  logic        busy_out, done_out, addr_nack_out, frame_ok_out;
  logic        served, ended, served2;
  logic [15:0] tail_out;
  logic [10:0] flow_dlpm_out;
  int          num_errors, tests_run, served_cnt, ended_cnt, served2_cnt;
  int          vals[5] = '{0, 408, 409, 3686, 4095};
  logic        bits[$];

  fdr_i2c_if link_if ();
  fdr_i2c_if fault_if ();
  fdr_flow_host #(.QTR_CYCLES(Q)) fdr_flow_host_inst (.bus(link_if), .clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .read_req_in(read_req_in), .busy_out(busy_out), .done_out(done_out),
    .addr_nack_out(addr_nack_out), .frame_ok_out(frame_ok_out),
    .flow_count_out(flow_count_out), .tail_out(tail_out), .flow_dlpm_out(flow_dlpm_out));
  fdr_sensor_dev fdr_sensor_dev_inst (.bus(link_if), .clk_sys_in(clk_sys_in), .rst_in(dev_rst),
    .flow_in(flow_in), .flow_valid_in(flow_valid_in), .repeat_mode_in(repeat_mode_in),
    .frame_end_out(ended), .read_served_out(served));
  fdr_sensor_dev fdr_sensor_dev_fault_inst (.bus(fault_if), .clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .flow_in(flow_in), .flow_valid_in(flow_valid_in),
    .repeat_mode_in(repeat_mode_in), .frame_end_out(), .read_served_out(served2));
  fdr_link_monitor fdr_link_monitor_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in || dev_rst),
    .m_scl_o(link_if.m_scl_o), .m_scl_oe(link_if.m_scl_oe), .m_sda_o(link_if.m_sda_o),
    .m_sda_oe(link_if.m_sda_oe), .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe),
    .scl(link_if.scl), .sda(link_if.sda));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge link_if.scl) bits.push_back(link_if.sda);
  always @(negedge link_if.sda) if (link_if.scl === 1'b1) bits.delete();
  always @(posedge clk_sys_in)
  begin
    if (served === 1'b1) served_cnt++;
    if (ended === 1'b1) ended_cnt++;
    if (served2 === 1'b1) served2_cnt++;
  end

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk_val

  task automatic close_out();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic publish(input int f, input int r);
    @(negedge clk_sys_in);
    flow_in        = 12'(f);
    repeat_mode_in = 1'(r);
    flow_valid_in  = 1'b1;
    @(negedge clk_sys_in);
    flow_valid_in  = 1'b0;
  endtask : publish

  // Mode 0: sensor held silent, 1: any consistent frame, 2: frame of the given sample.
  task automatic do_read(input int f, input int r, input int mode);
    int hi, lo, tl, ck, n, s0, e0;
    logic [53:0] got;
    hi = f >> 8;
    lo = f & 255;
    tl = r ? (hi << 8) | lo : 0;
    ck = (256 - (hi + lo + (tl >> 8) + (tl & 255)) % 256) % 256;
    s0 = served_cnt;
    e0 = ended_cnt;
    @(negedge clk_sys_in);
    read_req_in = 1'b1;
    @(negedge clk_sys_in);
    read_req_in = 1'b0;
    chk_bit("busy", 1'b1, busy_out);
    repeat (3) @(negedge clk_sys_in);
    read_req_in = 1'b1;
    @(negedge clk_sys_in);
    read_req_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 1200)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk_bit("done_in_time", 1'b1, n < (mode == 0 ? 200 : 1000));
    chk_bit("addr_nack", mode == 0, addr_nack_out);
    chk_bit("frame_ok", mode != 0, frame_ok_out);
    if (mode == 2)
    begin
      chk_val("flow", f, flow_count_out);
      chk_val("tail", tl, tail_out);
      if (f <= 3686) chk_val("dlpm", f < 409 ? 0 : (f - 409) * 2000 / 3277, flow_dlpm_out);
      // Six nine-bit units plus the clock rise that precedes the STOP.
      chk_val("bit_count", 55, bits.size());
      for (int k = 0; k < 54 && k < bits.size(); k++) got[53 - k] = bits[k];
      chk_val("wire", {8'ha1, 1'b0, 8'(ck), 1'b0, 8'(hi), 1'b0, 8'(lo), 1'b0, 8'(tl >> 8),
                       1'b0, 8'(tl), 1'b1}, got);
    end
    @(negedge clk_sys_in);
    chk_bit("done_pulse", 1'b0, done_out);
    repeat (4) @(negedge clk_sys_in);
    chk_bit("not_queued", 1'b0, busy_out);
    chk_val("served", s0 + (mode != 0), served_cnt);
    chk_val("stops", e0 + (mode != 0), ended_cnt);
  endtask : do_read

  // One bit on the faulty link: its clock runs at a 64 ns period only inside frames.
  task automatic fbit(input logic b, output logic s);
    fault_if.m_sda_oe = !b;
    #16 fault_if.m_scl_oe = 1'b0;
    #16 s = fault_if.sda;
    #16 fault_if.m_scl_oe = 1'b1;
    #16;
  endtask : fbit

  task automatic probe(input logic [7:0] a);
    logic s;
    int   s0;
    s0 = served2_cnt;
    fault_if.m_sda_oe = 1'b1;
    #16 fault_if.m_scl_oe = 1'b1;
    for (int i = 7; i >= 0; i--) fbit(a[i], s);
    fbit(1'b1, s);
    chk_bit("probe_ack", a != FDR_ADDR_RD, s);
    for (int i = 0; i < 9; i++) fbit(1'b1, s);
    fault_if.m_sda_oe = 1'b1;
    #16 fault_if.m_scl_oe = 1'b0;
    #16 fault_if.m_sda_oe = 1'b0;
    #200;
    chk_val("probe_served", s0 + (a == FDR_ADDR_RD), served2_cnt);
  endtask : probe

  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end

  initial
  begin
    int f;
    int r;
    {rst_in, dev_rst, read_req_in, flow_valid_in, repeat_mode_in} = 5'h18;
    flow_in = 12'h000;
    {fault_if.m_scl_o, fault_if.m_sda_o, fault_if.m_scl_oe, fault_if.m_sda_oe} = 4'h0;
    f = $urandom(32'hf21b845d);
    repeat (12) @(negedge clk_sys_in);
    rst_in = 1'b0;
    do_read(0, 0, 0);
    dev_rst = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      f = i < 5 ? vals[i] : $urandom_range(3686);
      r = i < 5 ? i % 2 : $urandom_range(1);
      if (i == 5) publish(123, 1);
      publish(f, r);
      do_read(f, r, 1);
      do_read(f, r, 2);
    end
    probe(8'ha1);
    probe(8'ha0);
    probe(8'h51);
    repeat (2) probe(8'($urandom) | 8'h01);
    close_out();
  end
endmodule : tb_i2c_flow_data_readout
`default_nettype wire
